// File: src/scc_defines.vh
// Constants for the two-coil chopper sequencer.
// Assumes a 200 MHz system clock; included by src/scc_chopper.v only.
`ifndef SCC_DEFINES_VH
`define SCC_DEFINES_VH
// System clock period in picoseconds (5 ns).
`define SCC_CLK_PS 5000
// Blank times in nanoseconds for the four select codes.
`define SCC_BLANK0_NS 600
`define SCC_BLANK1_NS 900
`define SCC_BLANK2_NS 1200
`define SCC_BLANK3_NS 1500
// Blank times in system cycles (ns / 5), sized for the 9-bit blank count.
`define SCC_BLANK0_CYC 9'h078
`define SCC_BLANK1_CYC 9'h0B4
`define SCC_BLANK2_CYC 9'h0F0
`define SCC_BLANK3_CYC 9'h12C
// Low-side error limit and off-time in chopper periods.
`define SCC_ERR_LIMIT 2'h3
`define SCC_OFF_PERIODS 6'h3F
// Fast decay base length in system cycles, and its mixed-decay shrink shift.
`define SCC_FAST_CYC 16'h00C8
`define SCC_MIX_SHIFT 2
// Phase codes of one bridge.
`define SCC_PH_OFF 3'h0
`define SCC_PH_BLANK 3'h1
`define SCC_PH_ON 3'h2
`define SCC_PH_FAST 3'h3
`define SCC_PH_SLOW 3'h4
`define SCC_PH_TRIP 3'h5
`endif

// File: src/scc_chopper.v
// Two-bridge fixed-frequency current chopper with decay sequencing.
// Assumes all sense and control pins are asynchronous and are synchronised
// here; the oscillator is sampled as a pin, not used as a clock.
//
// Behaviour
// RL1: Both coils chop at one oscillator frequency, bridge B half a period later.
// RL2: Each cycle steps on, then fast decay, then slow decay; with mixed decay disabled the code goes from on straight to slow decay.
// RL3: Fast decay: both highs off, low side opposite the polarity on.
// RL4: Slow decay: both low-side transistors on regardless of polarity.
// RL5: A polarity change restarts that bridge's cycle at once.
// RL6: Mixed decay shortens fast decay as the on phase grows.
// RL7: Bridge A starts on the rising oscillator edge, bridge B on falling.
// RL8: On phase ends when sensed current reaches target.
// RL9: High-side overcurrent flagged when supply-threshold comparator trips.
// RL10: Short and overcurrent detection are masked during the blank interval.
// RL11: External oscillator at most 100 kHz and never left open.
// RL12: Controller enables mixed decay on falling current, off at standstill.
// RL13: With continuous mixed decay, chopper frequency at least 36 kHz.
// RL14: Voltage PWM mode toggles polarity; half duty gives zero current.
// RL15: Low-side overcurrent: bridge off for the cycle; third error holds 63 cycles.
// RL16: Two select inputs pick blank time 0.6, 0.9, 1.2 or 1.5 us.
// RL17: Bridge does not switch on if sense threshold already exceeded.
// RL18: Mixed-decay enables are active low; low polarity drives out1 to out2.
// RL19: Chopper period equals one oscillator period, on phase after blanking.
`timescale 1ns/1ps
`default_nettype none
`include "scc_defines.vh"

module scc_chopper
(
  input wire i_sys_clk,
  input wire i_nrst,
  input wire i_clk_en,
  input wire i_osc,
  input wire i_coil_a_polarity,
  input wire i_coil_b_polarity,
  input wire i_coil_a_mixed_decay_en_n,
  input wire i_coil_b_mixed_decay_en_n,
  input wire i_coil_a_sense_input,
  input wire i_coil_b_sense_input,
  input wire i_coil_a_lowside_ovc,
  input wire i_coil_b_lowside_ovc,
  input wire i_high_side_ovc,
  input wire i_blank_select_lo,
  input wire i_blank_select_hi,
  output reg [3:0] o_gate_a,
  output reg [3:0] o_gate_b,
  output reg o_high_side_err,
  output reg o_err_a,
  output reg o_err_b
);

  // Inputs in one vector so a single two-stage synchroniser serves them all.
  localparam NIN = 12;
  wire [NIN-1:0] raw_in;
  reg [NIN-1:0] sync1_q;
  reg [NIN-1:0] sync2_q;
  reg osc_prev_q;
  reg [1:0] bsel_q;
  reg [8:0] blank_cyc;
  wire osc_s;
  wire osc_rise;
  wire osc_fall;
  wire blank_any;
  wire [5:0] gate_a_w;
  wire [5:0] gate_b_w;
  wire hs_err_w;

  assign raw_in = {i_osc, i_coil_a_polarity, i_coil_b_polarity,
    i_coil_a_mixed_decay_en_n, i_coil_b_mixed_decay_en_n,
    i_coil_a_sense_input, i_coil_b_sense_input, i_coil_a_lowside_ovc,
    i_coil_b_lowside_ovc, i_high_side_ovc, i_blank_select_lo,
    i_blank_select_hi};

  // Two flip-flops per pin; only the second stage feeds any logic.
  always @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sync1_q <= {NIN{1'b0}};
      sync2_q <= {NIN{1'b0}};
      osc_prev_q <= 1'b0;
      bsel_q <= 2'h0;
    end
    else if (i_clk_en)
    begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
      osc_prev_q <= osc_s;
      bsel_q <= {sync2_q[0], sync2_q[1]};
    end
  end

  assign osc_s = sync2_q[11];
  assign osc_rise = osc_s & ~osc_prev_q; // [RL7]
  assign osc_fall = ~osc_s & osc_prev_q; // [RL7]

  // Blank length from the two select pins, high select is the upper bit.
  always @*
  begin
    case (bsel_q) // [RL16]
      2'h0: blank_cyc = `SCC_BLANK0_CYC;
      2'h1: blank_cyc = `SCC_BLANK1_CYC;
      2'h2: blank_cyc = `SCC_BLANK2_CYC;
      default: blank_cyc = `SCC_BLANK3_CYC;
    endcase
  end

  // Bridge A follows the rising edge and bridge B the falling edge, which
  // yields the half-period offset without a second clock.
  scc_bridge u_bridge_a
  (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_clk_en(i_clk_en),
    .i_start(osc_rise), // [RL1]
    .i_pol(sync2_q[10]),
    .i_mix_n(sync2_q[8]),
    .i_sense(sync2_q[6]),
    .i_ls_ovc(sync2_q[4]),
    .i_blank_cyc(blank_cyc),
    .o_gate(gate_a_w[3:0]),
    .o_blank(gate_a_w[4]),
    .o_err(gate_a_w[5])
  );

  scc_bridge u_bridge_b
  (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_clk_en(i_clk_en),
    .i_start(osc_fall), // [RL1]
    .i_pol(sync2_q[9]),
    .i_mix_n(sync2_q[7]),
    .i_sense(sync2_q[5]),
    .i_ls_ovc(sync2_q[3]),
    .i_blank_cyc(blank_cyc),
    .o_gate(gate_b_w[3:0]),
    .o_blank(gate_b_w[4]),
    .o_err(gate_b_w[5])
  );

  // A switching edge on either bridge can spike the supply sense, so the
  // high-side check is masked while either bridge is blanking.
  assign blank_any = gate_a_w[4] | gate_b_w[4];
  assign hs_err_w = sync2_q[2] & ~blank_any; // [RL9] [RL10]

  // Registered outputs; the high-side flag is sticky until reset.
  always @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_gate_a <= 4'h0;
      o_gate_b <= 4'h0;
      o_high_side_err <= 1'b0;
      o_err_a <= 1'b0;
      o_err_b <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_gate_a <= gate_a_w[3:0];
      o_gate_b <= gate_b_w[3:0];
      o_high_side_err <= o_high_side_err | hs_err_w; // [RL9]
      o_err_a <= gate_a_w[5];
      o_err_b <= gate_b_w[5];
    end
  end

endmodule

// One full bridge sequencer. Gate bits: [3] high1, [2] low1, [1] high2,
// [0] low2. Polarity low drives out1 high and out2 low.
module scc_bridge
(
  input wire i_sys_clk,
  input wire i_nrst,
  input wire i_clk_en,
  input wire i_start,
  input wire i_pol,
  input wire i_mix_n,
  input wire i_sense,
  input wire i_ls_ovc,
  input wire [8:0] i_blank_cyc,
  output reg [3:0] o_gate,
  output wire o_blank,
  output wire o_err
);

  reg [2:0] ph_q;
  reg [2:0] ph_d;
  reg [15:0] cnt_q;
  reg [15:0] cnt_d;
  reg [15:0] on_len_q;
  reg [15:0] on_len_d;
  reg [1:0] err_cnt_q;
  reg [1:0] err_cnt_d;
  reg [5:0] hold_q;
  reg [5:0] hold_d;
  reg pol_q;
  reg [15:0] fast_len;
  wire pol_chg;
  wire restart;

  assign pol_chg = i_pol ^ pol_q;
  assign restart = i_start | pol_chg; // [RL5]
  assign o_blank = (ph_q == `SCC_PH_BLANK);
  assign o_err = (hold_q != 6'h0);

  // Mixed decay trims the fast phase by a share of the last on time, so a
  // long on phase gets less fast decay and the mix settles by itself.
  always @*
  begin
    if (!i_mix_n && ((on_len_q >> `SCC_MIX_SHIFT) < `SCC_FAST_CYC))
      fast_len = `SCC_FAST_CYC - (on_len_q >> `SCC_MIX_SHIFT); // [RL6]
    else if (!i_mix_n)
      fast_len = 16'h0001; // [RL6]
    else
      fast_len = 16'h0000;
  end

  // Phase sequencer for one chopper period.
  always @*
  begin
    ph_d = ph_q;
    cnt_d = cnt_q + 16'h0001;
    on_len_d = on_len_q;
    err_cnt_d = err_cnt_q;
    hold_d = hold_q;
    if (restart)
    begin
      cnt_d = 16'h0000;
      if (i_start && hold_q != 6'h0)
      begin
        hold_d = hold_q - 6'h01; // [RL15]
        ph_d = `SCC_PH_OFF;
      end
      else if (hold_q != 6'h0)
        ph_d = `SCC_PH_OFF;
      else if (i_sense)
        ph_d = `SCC_PH_SLOW; // [RL17]
      else
        ph_d = `SCC_PH_BLANK; // [RL19]
    end
    else
    begin
      case (ph_q) // [RL2]
        `SCC_PH_BLANK:
          if (cnt_q >= {7'h00, i_blank_cyc} - 16'h0001)
          begin
            ph_d = `SCC_PH_ON; // [RL10]
            cnt_d = 16'h0000;
          end
        `SCC_PH_ON:
          if (i_ls_ovc)
          begin
            ph_d = `SCC_PH_TRIP; // [RL15]
            if (err_cnt_q == `SCC_ERR_LIMIT - 2'h1)
            begin
              err_cnt_d = 2'h0;
              hold_d = `SCC_OFF_PERIODS;
            end
            else
              err_cnt_d = err_cnt_q + 2'h1;
          end
          else if (i_sense)
          begin
            on_len_d = cnt_q; // [RL8]
            cnt_d = 16'h0000;
            ph_d = (fast_len == 16'h0000) ? `SCC_PH_SLOW : `SCC_PH_FAST;
          end
        `SCC_PH_FAST:
          if (cnt_q >= fast_len - 16'h0001)
            ph_d = `SCC_PH_SLOW; // [RL2]
        `SCC_PH_SLOW: ph_d = `SCC_PH_SLOW;
        `SCC_PH_TRIP: ph_d = `SCC_PH_TRIP;
        `SCC_PH_OFF: ph_d = `SCC_PH_OFF;
        default: ph_d = `SCC_PH_OFF;
      endcase
    end
  end

  // State registers of the bridge.
  always @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ph_q <= `SCC_PH_OFF;
      cnt_q <= 16'h0000;
      on_len_q <= 16'h0000;
      err_cnt_q <= 2'h0;
      hold_q <= 6'h00;
      pol_q <= 1'b0;
    end
    else if (i_clk_en)
    begin
      ph_q <= ph_d;
      cnt_q <= cnt_d;
      on_len_q <= on_len_d;
      err_cnt_q <= err_cnt_d;
      hold_q <= hold_d;
      pol_q <= i_pol;
    end
  end

  // Gate pattern per phase; blanking already drives the on pattern.
  always @*
  begin
    case (ph_q)
      `SCC_PH_BLANK, `SCC_PH_ON:
        o_gate = i_pol ? 4'h6 : 4'h9;
      `SCC_PH_FAST:
        o_gate = i_pol ? 4'h1 : 4'h4; // [RL3]
      `SCC_PH_SLOW:
        o_gate = 4'h5; // [RL4]
      default:
        o_gate = 4'h0; // [RL15]
    endcase
  end

endmodule
`default_nettype wire

// File: verif/scc_chopper_chk.sv
// Checker for the two-coil chopper: gate patterns, order and error flags.
// Assumes the oscillator period is far longer than the input sync delay.
`timescale 1ns/1ps
`default_nettype none
module scc_chopper_chk
(
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_osc,
  input wire logic i_coil_a_polarity,
  input wire logic i_coil_b_polarity,
  input wire logic [3:0] o_gate_a,
  input wire logic [3:0] o_gate_b,
  input wire logic o_high_side_err,
  input wire logic o_err_a
);
  logic [7:0] osc_h_q;
  logic [7:0] pa_h_q;
  logic [7:0] pb_h_q;
  logic [9:0] on_cnt_q;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  // Short input histories span the sync delay, so a cause can be found.
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      osc_h_q <= 8'h00;
      pa_h_q <= 8'h00;
      pb_h_q <= 8'h00;
      on_cnt_q <= 10'h000;
    end
    else
    begin
      osc_h_q <= {osc_h_q[6:0], i_osc};
      pa_h_q <= {pa_h_q[6:0], i_coil_a_polarity};
      pb_h_q <= {pb_h_q[6:0], i_coil_b_polarity};
      on_cnt_q <= (o_gate_a == 4'h9) ? on_cnt_q + 10'h001 : 10'h000;
    end
  end
  // A new cycle is slow decay followed by a drive pattern.
  sequence s_start_a;
    (o_gate_a == 4'h5) ##1 (o_gate_a == 4'h9 || o_gate_a == 4'h6);
  endsequence
  sequence s_start_b;
    (o_gate_b == 4'h5) ##1 (o_gate_b == 4'h9 || o_gate_b == 4'h6);
  endsequence
  legal_gate_a: assert property (
    o_gate_a inside {4'h0, 4'h9, 4'h6, 4'h4, 4'h1, 4'h5})
    else $error("Bridge A shows a forbidden gate pattern.");
  legal_gate_b: assert property (
    o_gate_b inside {4'h0, 4'h9, 4'h6, 4'h4, 4'h1, 4'h5})
    else $error("Bridge B shows a forbidden gate pattern.");
  fast_order_a: assert property (
    (o_gate_a == 4'h4) && ($past(o_gate_a) != 4'h4) |-> $past(o_gate_a) == 4'h9)
    else $error("Fast decay did not follow the on phase.");
  blank_len_a: assert property (
    (o_gate_a inside {4'h4, 4'h5}) && ($past(o_gate_a) == 4'h9)
    |-> on_cnt_q >= 10'h078)
    else $error("On phase ended inside the blank time.");
  start_edge_a: assert property (
    s_start_a ##0 (pa_h_q == 8'h00 || pa_h_q == 8'hFF)
    |-> |(osc_h_q[6:0] & ~osc_h_q[7:1]))
    else $error("Bridge A started away from a rising edge.");
  start_edge_b: assert property (
    s_start_b ##0 (pb_h_q == 8'h00 || pb_h_q == 8'hFF)
    |-> |(~osc_h_q[6:0] & osc_h_q[7:1]))
    else $error("Bridge B started away from a falling edge.");
  hold_off_a: assert property (
    o_err_a |-> o_gate_a == 4'h0)
    else $error("Bridge A drives while held off.");
  hs_sticky_a: assert property (
    o_high_side_err |=> o_high_side_err)
    else $error("High-side error flag dropped without reset.");
endmodule
`default_nettype wire

// File: verif/scc_bridge_model.sv
// Behavioural bridge and coil: current magnitude and its comparators.
// Assumes the chopper's gate codes; a short is applied only when asked.
`timescale 1ns/1ps
`default_nettype none
module scc_bridge_model
(
  input wire logic i_sys_clk,
  input wire logic [3:0] i_gate,
  input wire logic [9:0] i_target,
  input wire logic i_short,
  output logic o_sense,
  output logic o_ls_ovc
);
  logic [10:0] cur_q = 11'h000;
  logic drive;
  // Only the two diagonal patterns push current into the coil.
  assign drive = (i_gate == 4'h9) || (i_gate == 4'h6);
  assign o_sense = (cur_q >= {1'b0, i_target});
  assign o_ls_ovc = i_short && drive;
  // Fast decay works against the coil, so it drains twice as quickly.
  always @(posedge i_sys_clk)
  begin
    if (drive)
      cur_q <= cur_q + 11'h001;
    else if ((i_gate == 4'h4 || i_gate == 4'h1) && cur_q > 11'h001)
      cur_q <= cur_q - 11'h002;
    else if (cur_q != 11'h000)
      cur_q <= cur_q - 11'h001;
  end
endmodule
`default_nettype wire

// File: verif/scc_chopper_tb.sv
// Self-checking bench for the two-coil chopper with modelled bridges.
// Assumes a 200 MHz clock; the oscillator made here runs at 100 kHz.
`timescale 1ns/1ps
`default_nettype none
module scc_chopper_tb;
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_osc = 1'b1;
  logic pa = 1'b0;
  logic mda = 1'b1;
  logic sha = 1'b0;
  logic hs = 1'b0;
  logic [1:0] bsel = 2'h0;
  logic [9:0] ta = 10'h190;
  logic [10:0] ocnt = 11'h000;
  logic sa, sb, la, lb, o_high_side_err, o_err_a, o_err_b;
  logic [3:0] o_gate_a, o_gate_b;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  int k, n;
  int f [4];
  scc_chopper DUT
  (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_clk_en(1'b1), .i_osc(i_osc),
    .i_coil_a_polarity(pa), .i_coil_b_polarity(1'b0),
    .i_coil_a_mixed_decay_en_n(mda), .i_coil_b_mixed_decay_en_n(1'b1),
    .i_coil_a_sense_input(sa), .i_coil_b_sense_input(sb),
    .i_coil_a_lowside_ovc(la), .i_coil_b_lowside_ovc(lb),
    .i_high_side_ovc(hs), .i_blank_select_lo(bsel[0]),
    .i_blank_select_hi(bsel[1]), .o_gate_a(o_gate_a), .o_gate_b(o_gate_b),
    .o_high_side_err(o_high_side_err), .o_err_a(o_err_a), .o_err_b(o_err_b)
  );
  scc_bridge_model coil_a
  (
    .i_sys_clk(i_sys_clk), .i_gate(o_gate_a), .i_target(ta),
    .i_short(sha), .o_sense(sa), .o_ls_ovc(la)
  );
  scc_bridge_model coil_b
  (
    .i_sys_clk(i_sys_clk), .i_gate(o_gate_b), .i_target(10'h190),
    .i_short(1'b0), .o_sense(sb), .o_ls_ovc(lb)
  );
  always #2.5 i_sys_clk = ~i_sys_clk;
  // Oscillator of 2000 cycles, the fastest an external source may be.
  always @(posedge i_sys_clk)
  begin
    ocnt <= (ocnt == 11'h7CF) ? 11'h000 : ocnt + 11'h001;
    i_osc <= (ocnt < 11'h3E8);
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      failures++;
      report_and_stop;
    end
  end
  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tick(input int c);
    repeat (c) @(posedge i_sys_clk);
  endtask
  // Outputs are sampled at the falling edge, well clear of updates.
  task await_a(input logic [3:0] v);
    k = 0;
    @(negedge i_sys_clk);
    while (o_gate_a !== v && k < 4100)
    begin
      @(negedge i_sys_clk);
      k++;
    end
    check(o_gate_a, v);
  endtask
  task span_a(output int len);
    len = 0;
    while (o_gate_a === 4'h9 || o_gate_a === 4'h6 || o_gate_a === 4'h4 ||
      o_gate_a === 4'h1)
    begin
      @(negedge i_sys_clk);
      len++;
    end
  endtask
  initial
  begin
    tick(4);
    i_nrst <= 1'b1;
    @(negedge i_sys_clk);
    check(o_gate_a, 4'h0);
    await_a(4'h5);
    await_a(4'h9);
    k = 0;
    while (o_gate_b !== 4'h9 && k < 3000)
    begin
      @(negedge i_sys_clk);
      k++;
    end
    check(k, 1000);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge i_sys_clk);
      mda <= 1'b0;
      pa <= i[0];
      ta <= i[1] ? 10'h258 : 10'h096;
      await_a(4'h5);
      await_a(i[0] ? 4'h6 : 4'h9);
      while (o_gate_a === 4'h9 || o_gate_a === 4'h6)
        @(negedge i_sys_clk);
      check(o_gate_a, i[0] ? 4'h1 : 4'h4);
      span_a(f[i]);
      check(o_gate_a, 4'h5);
    end
    check(f[2] < f[0] && f[3] < f[1], 1'b1);
    for (int s = 0; s < 4; s++)
    begin
      @(posedge i_sys_clk);
      mda <= 1'b1;
      pa <= 1'b0;
      ta <= 10'h001;
      bsel <= 2'(s);
      await_a(4'h5);
      await_a(4'h9);
      span_a(n);
      check(n >= 120 + 60 * s && n <= 126 + 60 * s, 1'b1);
    end
    await_a(4'h9);
    @(posedge i_sys_clk);
    hs <= 1'b1;
    tick(20);
    hs <= 1'b0;
    await_a(4'h5);
    check(o_high_side_err, 1'b0);
    @(posedge i_sys_clk);
    hs <= 1'b1;
    tick(2);
    hs <= 1'b0;
    tick(100);
    @(negedge i_sys_clk);
    check(o_high_side_err, 1'b1);
    @(posedge i_sys_clk);
    ta <= 10'h000;
    k = 0;
    repeat (4000)
    begin
      @(negedge i_sys_clk);
      if (o_gate_a === 4'h9)
        k++;
    end
    check(k, 0);
    @(posedge i_sys_clk);
    ta <= 10'h320;
    await_a(4'h9);
    tick(50);
    pa <= 1'b1;
    await_a(4'h6);
    check(k <= 8, 1'b1);
    span_a(n);
    check(n >= 300, 1'b1);
    @(posedge i_sys_clk);
    ta <= 10'h190;
    sha <= 1'b1;
    tick(7000);
    @(negedge i_sys_clk);
    check(o_err_a, 1'b1);
    check(o_gate_a, 4'h0);
    check(o_err_b, 1'b0);
    @(posedge i_sys_clk);
    i_nrst <= 1'b0;
    sha <= 1'b0;
    tick(4);
    i_nrst <= 1'b1;
    tick(2);
    @(negedge i_sys_clk);
    check(o_err_a, 1'b0);
    check(o_high_side_err, 1'b0);
    await_a(4'h6);
    // Voltage PWM use: polarity toggled at half duty, each edge restarts.
    for (int p = 0; p < 4; p++)
    begin
      @(posedge i_sys_clk);
      pa <= p[0];
      await_a(p[0] ? 4'h6 : 4'h9);
      tick(50);
    end
    report_and_stop;
  end
endmodule
bind scc_chopper scc_chopper_chk u_chk
(
  .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_osc(i_osc),
  .i_coil_a_polarity(i_coil_a_polarity),
  .i_coil_b_polarity(i_coil_b_polarity), .o_gate_a(o_gate_a),
  .o_gate_b(o_gate_b), .o_high_side_err(o_high_side_err),
  .o_err_a(o_err_a)
);
`default_nettype wire
